// [hw/risc_consts.svh]
`ifndef RISC_CONSTS_SVH
`define RISC_CONSTS_SVH

// ==========================================================================
// Serial word layout
`define RISC_WORD_W 32
`define RISC_ADDR_W 5
`define RISC_DATA_W 27
`define RISC_NREG 32
`define RISC_REG_RST 27'h0000000

// ==========================================================================
// Register addresses
`define RISC_ADDR_SEL 5'h0B
`define RISC_ADDR_PIN 5'h0C

// ==========================================================================
// Fields of the selection register
`define RISC_F_MODE 0
`define RISC_F_BUFEN 3
`define RISC_F_IGNLOCK 6
`define RISC_F_HOLDEN 7
`define RISC_F_INV 8
`define RISC_F_PREDIV 9

// ==========================================================================
// Fields of the pin register
`define RISC_F_TYPE_LOW 0
`define RISC_F_TYPE_HIGH 2
`define RISC_F_SYNCAUTO 4
`define RISC_F_RBLEVEL 5
`define RISC_F_RBADDR 6

// ==========================================================================
// Selection codes
`define RISC_MODE_MAN_MAX 3'h2
`define RISC_MODE_PIN 3'h3
`define RISC_CODE_HOLD 2'h3

`endif

// [hw/risc_pkg.sv]
// ==========================================================================
// Types of the reference select block
package risc_pkg;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } risc_state_e;

  typedef enum logic [1:0] {
    PIN_IN = 2'h0,
    PIN_HOLD = 2'h1,
    PIN_READBACK = 2'h2,
    PIN_LOCK = 2'h3
  } risc_pin_e;

endpackage

// [hw/risc_serial_port.sv]
`timescale 1ns/100ps
`default_nettype none
`include "risc_consts.svh"

module risc_serial_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  input wire logic latch_enable_pin,
  // Decoded write
  output logic wrStb,
  output logic [`RISC_ADDR_W-1:0] wrAddr,
  output logic [`RISC_DATA_W-1:0] wrData,
  // Pin events
  output logic sclkRise,
  output logic leRise,
  output logic leFall,
  output logic leLevel
);

  // ========================================================================
  // Synchronisers and edge finders, bit 0 clock, bit 1 data, bit 2 latch
  logic [2:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
  logic [`RISC_WORD_W-1:0] shift_q, shift_d;
  logic wrStb_q, wrStb_d;
  logic [`RISC_ADDR_W-1:0] wrAddr_q, wrAddr_d;
  logic [`RISC_DATA_W-1:0] wrData_q, wrData_d;

  assign sclkRise = s2_q[0] & ~s3_q[0];
  assign leRise = s2_q[2] & ~s3_q[2];
  assign leFall = ~s2_q[2] & s3_q[2];
  assign leLevel = s2_q[2];
  assign wrStb = wrStb_q;
  assign wrAddr = wrAddr_q;
  assign wrData = wrData_q;

  always_comb begin
    s1_d = {latch_enable_pin, serial_data_pin, serial_clock_pin};
    s2_d = s1_q;
    s3_d = s2_q;
    shift_d = shift_q;
    // Shifting goes on whatever the latch level, so readback clocks load it too.
    if (sclkRise) begin
      shift_d = {shift_q[`RISC_WORD_W-2:0], s2_q[1]}; // R1 R7
    end
    wrStb_d = leRise; // R2
    wrAddr_d = wrAddr_q;
    wrData_d = wrData_q;
    if (leRise) begin
      wrAddr_d = shift_q[`RISC_ADDR_W-1:0]; // R3
      wrData_d = shift_q[`RISC_WORD_W-1:`RISC_ADDR_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      shift_q <= 32'h00000000;
      wrStb_q <= 1'b0;
      wrAddr_q <= 5'h00;
      wrData_q <= `RISC_REG_RST;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      shift_q <= shift_d;
      wrStb_q <= wrStb_d;
      wrAddr_q <= wrAddr_d;
      wrData_q <= wrData_d;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_shift_in_bit: assert property (sclkRise |=> shift_q[0] == $past(s2_q[1])) // R1
    else $error("serial data bit not shifted in on clock rise");
  a_addr_from_tail: assert property (leRise |=> wrStb && wrAddr == $past(shift_q[4:0])) // R3
    else $error("write address not taken from last five bits");
  a_shift_during_le: assert property (sclkRise && leLevel |=> shift_q[31:1] == $past(shift_q[30:0])) // R7
    else $error("shift register stalled while latch high");

endmodule

`default_nettype wire

// [hw/risc_ref_select.sv]
`timescale 1ns/100ps
`default_nettype none
`include "risc_consts.svh"

// ==========================================================================
// Notes on behaviour
// R1 - Serial data enters the shift register on each serial clock rise.
// R2 - Latch enable rise copies the shift register into the addressed register.
// R3 - The register address is the last five bits shifted in.
// R4 - Host returns serial clock, data and latch lines low after a transfer.
// R5 - Host uses extra clocks or double writes for large divides or delays.
// R6 - With automatic sync set, latch enable fall issues a sync pulse.
// R7 - Clock rises during readback still shift; a later latch rise writes.
// R8 - Readback appears only on a status pin set to readback type.
// R9 - Each reference input has a pre-divider of 1, 2, 4 or 8.
// R10 - Modes 0, 1, 2 hold reference input 0, 1, 2 active.
// R11 - Manual selection runs the chosen input buffer despite its enable.
// R12 - Manual mode with holdover enters holdover on lock loss unless ignored.
// R13 - Manual mode leaves holdover onto the manually selected input.
// R14 - Mode 3 takes the active input from the two status select pins.
// R15 - In mode 3 any select pin change is a switch event.
// R16 - Software should ignore lock loss in pin-select mode.
// R17 - A status pin selects only when its type is input.
// R18 - A status pin configured as output reads as zero.
// R19 - Pin code 00, 01, 10 pick inputs 0, 1, 2; 11 holds over.
// R20 - Polarity invert flips both select pins before decoding.
// R21 - Without holdover a switch event moves the active input at once.
// R22 - With holdover a switch event holds over, then completes the switch.
// R23 - Holdover ends when reference loop lock rises again.
module risc_ref_select (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Serial programming pins
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  input wire logic latch_enable_pin,
  // Status select pin, low
  input wire logic status_select_pin_low,
  output logic status_select_pin_low_value,
  output logic status_select_pin_low_oe,
  // Status select pin, high
  input wire logic status_select_pin_high,
  output logic status_select_pin_high_value,
  output logic status_select_pin_high_oe,
  // Reference loop status
  input wire logic refLoopDigitalLock,
  // Selection results
  output logic [1:0] activeInput,
  output logic holdoverActive,
  output logic [2:0] inputBufferEnable,
  output logic [11:0] refPreDivide,
  output logic syncPulse
);

  // ========================================================================
  // Helpers
  function automatic logic [2:0] oneHot3(input logic [1:0] sel);
    oneHot3 = 3'h0;
    if (sel != `RISC_CODE_HOLD) begin
      oneHot3 = 3'h1 << sel;
    end
  endfunction

  function automatic logic [3:0] ratioOf(input logic [1:0] code);
    ratioOf = 4'h1 << code; // R9
  endfunction

  function automatic logic pinDrive(input risc_pkg::risc_pin_e t, input logic hold,
                                    input logic rb, input logic lock);
    pinDrive = 1'b0;
    unique case (t)
      risc_pkg::PIN_IN: pinDrive = 1'b0;
      risc_pkg::PIN_HOLD: pinDrive = hold;
      risc_pkg::PIN_READBACK: pinDrive = rb; // R8
      risc_pkg::PIN_LOCK: pinDrive = lock;
    endcase
  endfunction

  // ========================================================================
  // Serial front end
  logic wrStb, sclkRise, leRise, leFall, leLevel;
  logic [`RISC_ADDR_W-1:0] wrAddr;
  logic [`RISC_DATA_W-1:0] wrData;

  risc_serial_port uSerial (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .serial_clock_pin(serial_clock_pin),
    .serial_data_pin(serial_data_pin),
    .latch_enable_pin(latch_enable_pin),
    .wrStb(wrStb),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .sclkRise(sclkRise),
    .leRise(leRise),
    .leFall(leFall),
    .leLevel(leLevel)
  );

  // ========================================================================
  // Register bank
  logic [`RISC_DATA_W-1:0] bank_q [`RISC_NREG];
  logic [`RISC_DATA_W-1:0] bank_d [`RISC_NREG];

  always_comb begin
    bank_d = bank_q;
    if (wrStb) begin
      bank_d[wrAddr] = wrData; // R2
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `RISC_NREG; i++) begin
        bank_q[i] <= `RISC_REG_RST;
      end
    end else begin
      bank_q <= bank_d;
    end
  end

  logic [`RISC_DATA_W-1:0] selReg, pinReg;
  logic [2:0] mode, bufCfg;
  logic modeManual, modePin, holdEn, ignoreLock, selInv, syncAuto, rbLevel;
  logic [`RISC_ADDR_W-1:0] rbAddr;
  logic [5:0] preDivCodes;
  risc_pkg::risc_pin_e lowType, highType;

  assign selReg = bank_q[`RISC_ADDR_SEL];
  assign pinReg = bank_q[`RISC_ADDR_PIN];
  assign mode = selReg[`RISC_F_MODE +: 3];
  assign bufCfg = selReg[`RISC_F_BUFEN +: 3];
  assign ignoreLock = selReg[`RISC_F_IGNLOCK];
  assign holdEn = selReg[`RISC_F_HOLDEN];
  assign selInv = selReg[`RISC_F_INV];
  assign preDivCodes = selReg[`RISC_F_PREDIV +: 6];
  assign lowType = risc_pkg::risc_pin_e'(pinReg[`RISC_F_TYPE_LOW +: 2]);
  assign highType = risc_pkg::risc_pin_e'(pinReg[`RISC_F_TYPE_HIGH +: 2]);
  assign syncAuto = pinReg[`RISC_F_SYNCAUTO];
  assign rbLevel = pinReg[`RISC_F_RBLEVEL];
  assign rbAddr = pinReg[`RISC_F_RBADDR +: 5];
  assign modeManual = mode <= `RISC_MODE_MAN_MAX;
  assign modePin = mode == `RISC_MODE_PIN; // R14

  // ========================================================================
  // Selection control
  risc_pkg::risc_state_e state_q, state_d;
  logic [1:0] active_q, active_d, target_q, target_d, codePrev_q, codePrev_d;
  logic lowS1_q, lowS1_d, lowS2_q, lowS2_d, highS1_q, highS1_d, highS2_q, highS2_d;
  logic lockPrev_q, lockPrev_d, modePinPrev_q, modePinPrev_d;
  logic hold_q, hold_d, sync_q, sync_d, lowOut_q, lowOut_d, lowOe_q, lowOe_d;
  logic highOut_q, highOut_d, highOe_q, highOe_d;
  logic [2:0] bufEn_q, bufEn_d;
  logic [11:0] preDiv_q, preDiv_d;
  logic [`RISC_WORD_W-1:0] rb_q, rb_d;
  logic pinLow, pinHigh, lockFall, lockRise, lockLoss, pinChange, pinEvent;
  logic [1:0] pinCode;

  // A pin driven as an output never feeds the decoder, whatever the invert bit.
  assign pinLow = (lowType == risc_pkg::PIN_IN) & (lowS2_q ^ selInv); // R17 R18 R20
  assign pinHigh = (highType == risc_pkg::PIN_IN) & (highS2_q ^ selInv); // R17 R18 R20
  assign pinCode = {pinHigh, pinLow}; // R19
  assign lockFall = lockPrev_q & ~refLoopDigitalLock;
  assign lockRise = ~lockPrev_q & refLoopDigitalLock;
  assign lockLoss = lockFall & ~ignoreLock; // R12 R16
  assign pinChange = pinCode != codePrev_q; // R15
  assign pinEvent = pinChange | ~modePinPrev_q | lockLoss;

  always_comb begin
    state_d = state_q;
    active_d = active_q;
    target_d = target_q;
    lowS1_d = status_select_pin_low;
    lowS2_d = lowS1_q;
    highS1_d = status_select_pin_high;
    highS2_d = highS1_q;
    lockPrev_d = refLoopDigitalLock;
    codePrev_d = pinCode;
    modePinPrev_d = modePin;
    unique case (state_q)
      risc_pkg::ST_RUN: begin
        if (modeManual) begin
          active_d = mode[1:0]; // R10
          if (lockLoss && holdEn) begin
            state_d = risc_pkg::ST_HOLD; // R12
            target_d = mode[1:0];
          end
        end else if (modePin && pinEvent) begin
          target_d = pinCode;
          if (holdEn || pinCode == `RISC_CODE_HOLD) begin
            state_d = risc_pkg::ST_HOLD; // R22 R19
          end else begin
            active_d = pinCode; // R21
          end
        end
      end
      risc_pkg::ST_HOLD: begin
        if (modeManual) begin
          target_d = mode[1:0]; // R13
        end else if (modePin) begin
          target_d = pinCode;
        end else begin
          target_d = active_q;
        end
        if (target_d != `RISC_CODE_HOLD && (!holdEn || lockRise)) begin
          state_d = risc_pkg::ST_RUN; // R23
          active_d = target_d; // R22
        end
      end
      default: begin
        state_d = risc_pkg::ST_RUN;
      end
    endcase
    hold_d = state_d == risc_pkg::ST_HOLD;
    bufEn_d = bufCfg;
    if (modeManual) begin
      bufEn_d = bufCfg | oneHot3(mode[1:0]); // R11
    end else if (modePin) begin
      bufEn_d = bufCfg | oneHot3(pinCode);
    end
    preDiv_d = {ratioOf(preDivCodes[5:4]), ratioOf(preDivCodes[3:2]),
                ratioOf(preDivCodes[1:0])}; // R9
    sync_d = leFall & syncAuto; // R6
    rb_d = rb_q;
    // The word is captured before this latch's own write lands in the bank.
    if (leRise) begin
      rb_d = {bank_q[rbAddr], rbAddr}; // R8
    end else if (sclkRise && leLevel == rbLevel) begin
      rb_d = {rb_q[`RISC_WORD_W-2:0], 1'b0};
    end
    lowOe_d = lowType != risc_pkg::PIN_IN;
    highOe_d = highType != risc_pkg::PIN_IN;
    lowOut_d = pinDrive(lowType, hold_d, rb_d[`RISC_WORD_W-1], refLoopDigitalLock);
    highOut_d = pinDrive(highType, hold_d, rb_d[`RISC_WORD_W-1], refLoopDigitalLock);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= risc_pkg::ST_RUN;
      active_q <= 2'h0;
      target_q <= 2'h0;
      codePrev_q <= 2'h0;
      lowS1_q <= 1'b0;
      lowS2_q <= 1'b0;
      highS1_q <= 1'b0;
      highS2_q <= 1'b0;
      lockPrev_q <= 1'b0;
      modePinPrev_q <= 1'b0;
      hold_q <= 1'b0;
      sync_q <= 1'b0;
      bufEn_q <= 3'h0;
      preDiv_q <= 12'h111;
      rb_q <= 32'h00000000;
      lowOut_q <= 1'b0;
      lowOe_q <= 1'b0;
      highOut_q <= 1'b0;
      highOe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      active_q <= active_d;
      target_q <= target_d;
      codePrev_q <= codePrev_d;
      lowS1_q <= lowS1_d;
      lowS2_q <= lowS2_d;
      highS1_q <= highS1_d;
      highS2_q <= highS2_d;
      lockPrev_q <= lockPrev_d;
      modePinPrev_q <= modePinPrev_d;
      hold_q <= hold_d;
      sync_q <= sync_d;
      bufEn_q <= bufEn_d;
      preDiv_q <= preDiv_d;
      rb_q <= rb_d;
      lowOut_q <= lowOut_d;
      lowOe_q <= lowOe_d;
      highOut_q <= highOut_d;
      highOe_q <= highOe_d;
    end
  end

  assign activeInput = active_q;
  assign holdoverActive = hold_q;
  assign inputBufferEnable = bufEn_q;
  assign refPreDivide = preDiv_q;
  assign syncPulse = sync_q;
  assign status_select_pin_low_value = lowOut_q;
  assign status_select_pin_low_oe = lowOe_q;
  assign status_select_pin_high_value = highOut_q;
  assign status_select_pin_high_oe = highOe_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_bank_write: assert property (wrStb |=> bank_q[$past(wrAddr)] == $past(wrData)) // R2
    else $error("latched word not stored at decoded address");
  a_sync_on_fall: assert property (##1 syncPulse == $past(leFall && syncAuto)) // R6
    else $error("sync pulse does not follow latch fall");
  a_manual_active: assert property (modeManual && state_q == risc_pkg::ST_RUN
                                    |=> activeInput == $past(mode[1:0])) // R10
    else $error("manual mode did not select its input");
  a_manual_buffer: assert property (modeManual && mode[1:0] == 2'h1 |=> inputBufferEnable[1]) // R11
    else $error("manually selected buffer not running");
  a_hold_entry: assert property (modeManual && holdEn && lockLoss && state_q == risc_pkg::ST_RUN
                                 |=> holdoverActive ##1 activeInput == $past(activeInput, 2)) // R12
    else $error("lock loss did not enter holdover");
  a_hold_exit: assert property (state_q == risc_pkg::ST_HOLD && modeManual && lockRise
                                |=> !holdoverActive && activeInput == $past(mode[1:0])) // R13
    else $error("holdover exit did not use manual input");
  a_pin_switch: assert property (state_q == risc_pkg::ST_RUN && modePin && pinChange && !holdEn
                                 && pinCode != 2'h3 |=> activeInput == $past(pinCode)) // R21
    else $error("pin change did not switch input at once");
  a_pin_hold: assert property (state_q == risc_pkg::ST_RUN && modePin && pinChange && holdEn
                               |=> holdoverActive) // R22
    else $error("pin change with holdover did not hold");
  a_forced_hold: assert property (modePin && pinCode == 2'h3 |=> holdoverActive) // R19
    else $error("pin code three did not force holdover");
  a_output_zero: assert property (lowType != risc_pkg::PIN_IN |-> !pinCode[0]) // R18
    else $error("output-typed pin fed the decoder");
  a_predivide: assert property (preDivCodes[1:0] == 2'h3 |=> refPreDivide[3:0] == 4'h8) // R9
    else $error("pre-divider ratio wrong");

  c_manual_hold: cover property (modeManual && holdEn && lockLoss ##1 holdoverActive);
  c_pin_switch: cover property (modePin && pinChange ##1 activeInput == 2'h2);
  c_sync: cover property (syncPulse);
  c_readback: cover property (status_select_pin_low_oe && lowType == risc_pkg::PIN_READBACK
                              && sclkRise);

endmodule

`default_nettype wire

// [test/risc_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Host controller facing the serial port and the status select pins
module risc_host_model (
  // Clock
  input wire logic core_clk,
  // Serial programming pins
  output logic serial_clock_pin,
  output logic serial_data_pin,
  output logic latch_enable_pin,
  // Select levels driven by the host
  output logic selLowDrive,
  output logic selHighDrive,
  // Resolved level of the low status pin
  input wire logic selLowLevel
);
  initial begin
    serial_clock_pin = 1'b0;
    serial_data_pin = 1'b0;
    latch_enable_pin = 1'b0;
    selLowDrive = 1'b0;
    selHighDrive = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Each level stands four core cycles, so the two-flop synchroniser always sees it.
  task automatic shift_word(input logic [31:0] w, output logic [31:0] seen);
    for (int i = 31; i >= 0; i--) begin
      serial_data_pin <= w[i];
      serial_clock_pin <= 1'b0;
      tick(3);
      @(negedge core_clk);
      seen[i] = selLowLevel;
      @(posedge core_clk);
      serial_clock_pin <= 1'b1;
      tick(4);
    end
    serial_clock_pin <= 1'b0;
    serial_data_pin <= 1'b0;
    tick(1);
  endtask

  task automatic latch_pulse();
    latch_enable_pin <= 1'b1;
    tick(8);
    latch_enable_pin <= 1'b0;
    tick(8);
  endtask

  task automatic write_reg(input logic [4:0] addr, input logic [26:0] data);
    logic [31:0] seen;
    shift_word({data, addr}, seen);
    latch_pulse();
  endtask

  task automatic set_select(input logic [1:0] code);
    selHighDrive <= code[1];
    selLowDrive <= code[0];
  endtask
endmodule

`default_nettype wire

// [test/risc_ref_select_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "risc_consts.svh"

// ==========================================================================
// Self-checking bench for the reference select block
module risc_ref_select_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic refLoopDigitalLock = 1'b1;
  logic sck, sdat, latch, hostLow, hostHigh, pinLow, pinHigh;
  logic lowOut, lowOe, highOut, highOe, holdoverActive, syncPulse;
  logic [1:0] activeInput;
  logic [2:0] inputBufferEnable;
  logic [11:0] refPreDivide;
  logic [26:0] selShadow = 27'h0;
  int fails = 0;
  int nChecks = 0;
  int syncCount = 0;

  always #50 core_clk = ~core_clk;

  // A pin that the device drives shows its value; otherwise the host sets the level.
  assign pinLow = lowOe ? lowOut : hostLow;
  assign pinHigh = highOe ? highOut : hostHigh;

  always @(posedge core_clk) begin
    if (syncPulse === 1'b1) begin
      syncCount++;
    end
  end

  risc_ref_select i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .serial_clock_pin(sck), .serial_data_pin(sdat), .latch_enable_pin(latch),
    .status_select_pin_low(pinLow), .status_select_pin_low_value(lowOut),
    .status_select_pin_low_oe(lowOe), .status_select_pin_high(pinHigh),
    .status_select_pin_high_value(highOut), .status_select_pin_high_oe(highOe),
    .refLoopDigitalLock(refLoopDigitalLock), .activeInput(activeInput),
    .holdoverActive(holdoverActive), .inputBufferEnable(inputBufferEnable),
    .refPreDivide(refPreDivide), .syncPulse(syncPulse)
  );

  risc_host_model i_host (
    .core_clk(core_clk), .serial_clock_pin(sck), .serial_data_pin(sdat),
    .latch_enable_pin(latch), .selLowDrive(hostLow), .selHighDrive(hostHigh),
    .selLowLevel(pinLow)
  );

  // ========================================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  function automatic logic [26:0] selw(input logic [2:0] mode, input logic ign,
                                       input logic hold, input logic inv, input logic [5:0] pd);
    return {12'h000, pd, inv, hold, ign, 3'h0, mode};
  endfunction

  task automatic wr_sel(input logic [26:0] d);
    selShadow = d;
    i_host.write_reg(`RISC_ADDR_SEL, d);
    cyc(2);
  endtask

  task automatic wr_pin(input logic [1:0] tl, input logic sync, input logic [4:0] rba);
    i_host.write_reg(`RISC_ADDR_PIN, {16'h0000, rba, 1'b0, sync, 2'h0, tl});
    cyc(2);
  endtask

  task automatic conclude();
    if (fails == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_reset();
    chk(activeInput, 32'h0);
    chk(holdoverActive, 32'h0);
    chk(refPreDivide, 32'h111);
    chk(inputBufferEnable, 32'h1);
    chk(syncPulse, 32'h0);
  endtask

  task automatic t_manual();
    logic [1:0] c0, c1;
    logic [31:0] junk;
    for (int m = 0; m < 3; m++) begin
      c0 = m[1:0];
      c1 = c0 + 2'h1;
      // Extra leading bits must fall out of the shift register.
      if (m == 2) i_host.shift_word(32'hFFFF_FFFF, junk);
      wr_sel(selw(m[2:0], 1'b0, 1'b0, 1'b0, {c0, c1, 2'h3}));
      chk(activeInput, m);
      chk(inputBufferEnable, 32'h1 << m);
      chk(refPreDivide, {20'h0, 4'h1 << c0, 4'h1 << c1, 4'h8});
    end
  endtask

  task automatic t_hold_manual();
    wr_sel(selw(3'h1, 1'b0, 1'b1, 1'b0, 6'h00));
    refLoopDigitalLock <= 1'b0;
    cyc(3);
    chk(holdoverActive, 32'h1);
    chk(activeInput, 32'h1);
    refLoopDigitalLock <= 1'b1;
    cyc(3);
    chk(holdoverActive, 32'h0);
    chk(activeInput, 32'h1);
    wr_sel(selw(3'h1, 1'b1, 1'b1, 1'b0, 6'h00));
    refLoopDigitalLock <= 1'b0;
    cyc(3);
    chk(holdoverActive, 32'h0);
    refLoopDigitalLock <= 1'b1;
  endtask

  task automatic t_pin_select();
    wr_pin(2'h0, 1'b0, 5'h00);
    wr_sel(selw(3'h3, 1'b1, 1'b0, 1'b0, 6'h00));
    for (int c = 0; c < 4; c++) begin
      i_host.set_select(c[1:0]);
      cyc(5);
      if (c < 3) chk(activeInput, c);
      if (c < 3) chk(inputBufferEnable, 32'h1 << c);
      chk(holdoverActive, (c == 3));
    end
    wr_sel(selw(3'h3, 1'b1, 1'b0, 1'b1, 6'h00));
    i_host.set_select(2'h1);
    cyc(5);
    chk(activeInput, 32'h2);
    // Low pin now outputs the lock level; it must decode as zero whatever it shows.
    wr_pin(2'h3, 1'b0, 5'h00);
    refLoopDigitalLock <= 1'b0;
    i_host.set_select(2'h3);
    cyc(5);
    chk(lowOe, 32'h1);
    chk(activeInput, 32'h0);
    refLoopDigitalLock <= 1'b1;
  endtask

  task automatic t_hold_pin();
    wr_pin(2'h0, 1'b0, 5'h00);
    i_host.set_select(2'h0);
    wr_sel(selw(3'h3, 1'b1, 1'b1, 1'b0, 6'h00));
    refLoopDigitalLock <= 1'b0;
    cyc(2);
    refLoopDigitalLock <= 1'b1;
    cyc(4);
    chk(holdoverActive, 32'h0);
    i_host.set_select(2'h1);
    cyc(5);
    chk(holdoverActive, 32'h1);
    chk(activeInput, 32'h0);
    refLoopDigitalLock <= 1'b0;
    cyc(2);
    refLoopDigitalLock <= 1'b1;
    cyc(4);
    chk(holdoverActive, 32'h0);
    chk(activeInput, 32'h1);
    // The high pin reports holdover while a fall on the low pin forces a switch event.
    i_host.write_reg(`RISC_ADDR_PIN, {16'h0000, 5'h00, 1'b0, 1'b0, 2'h1, 2'h0});
    cyc(2);
    chk(highOut, 32'h0);
    i_host.set_select(2'h0);
    cyc(5);
    chk(highOe, 32'h1);
    chk(holdoverActive, 32'h1);
    chk(highOut, 32'h1);
  endtask

  task automatic t_sync();
    int base;
    base = syncCount;
    wr_pin(2'h0, 1'b1, 5'h00);
    chk(syncCount - base, 32'h1);
    wr_pin(2'h0, 1'b0, 5'h00);
    chk(syncCount - base, 32'h1);
  endtask

  task automatic t_readback();
    logic [31:0] seen;
    wr_pin(2'h2, 1'b0, `RISC_ADDR_SEL);
    wr_pin(2'h2, 1'b0, `RISC_ADDR_SEL);
    chk(lowOe, 32'h1);
    i_host.shift_word({selw(3'h2, 1'b0, 1'b0, 1'b0, 6'h00), `RISC_ADDR_SEL}, seen);
    chk(seen, {selShadow, `RISC_ADDR_SEL});
    i_host.latch_pulse();
    chk(activeInput, 32'h2);
  endtask

  // ========================================================================
  // Main sequence and watchdog
  initial begin
    cyc(5);
    sys_rst <= 1'b0;
    cyc(2);
    t_reset();
    t_manual();
    t_hold_manual();
    t_pin_select();
    t_hold_pin();
    t_sync();
    t_readback();
    conclude();
  end

  // Roughly twenty serial words of about three hundred cycles each fit well inside.
  initial begin
    cyc(20000);
    fails++;
    conclude();
  end
endmodule

`default_nettype wire
